// ---- logic/mcro_top.sv ----
`timescale 1ns/10ps
// How it works
// RULE1: Host clock is divided crystal, driven out
// RULE2: Three-bit select picks one of eight frequencies
// RULE3: Crystal options use integer division except code 3, which divides by 7.5 (15 half crystal cycles)
// RULE4: Low-frequency option comes from low-frequency source
// RULE5: Select resets to the 1 MHz code
// RULE6: Idle, transmit, receive output follows the select
// RULE7: Crystal is switched off while asleep
// RULE8: Sleep with low-frequency enable outputs slow clock
// RULE9: Sleep without low-frequency enable stops clock
// RULE10: Tail field adds 0/128/256/512 cycles before stop
// RULE11: Pending interrupt keeps host clock running
// RULE12: Mode change waits until interrupt is read
// RULE13: Crystal stays on while sleep is deferred
// RULE14: Any reset restores configuration defaults
// RULE15: Reset on pin zero, inverse on pin one
// RULE16: Software reset pulse lasts 50 to 470 us
// RULE17: Source changes and stops only at clock low
module mcro_top #(
  parameter int unsigned SWRST_LEN = mcro_pkg::SWRST_MIN_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mcro_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip mode and low-frequency source
  input wire logic sleep_cmd,
  input wire logic irq_pending,
  input wire logic lf_clk_in,
  // Host side pins
  output logic host_clock_out_pin,
  output logic gp_reset_out,
  output logic gp_reset_n_out,
  output logic xtal_enable
);
  import mcro_pkg::*;

  // ***************************************
  // Elaboration checks
  // ***************************************
  if (SWRST_LEN < 1 || SWRST_LEN >= (1 << SWRST_W)) begin : g_bad_len
    $error("SWRST_LEN does not fit the reset pulse counter");
  end

  typedef struct packed {
    mcro_state_e st;
    logic [2:0] sel;
    logic lfc;
    logic [1:0] tail;
    logic [SWRST_W-1:0] swcnt;
    logic [9:0] tcnt;
    logic use_lf;
    logic lf_q;
    logic lf_prev;
    logic host_clk;
    logic xtal_en;
    logic gp_rst;
    logic gp_rst_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mcro_top_s;

  mcro_top_s s_reg;
  mcro_top_s s_next;
  mcro_div_if div ();

  function automatic logic addr_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] b);
    addr_hit = (a == b);
  endfunction

  // ***************************************
  // Crystal divider
  // ***************************************
  mcro_divgen u_div (
    .pclk(pclk),
    .presetn(presetn),
    .g(div.gen)
  );

  assign div.period = mcro_period(s_reg.sel); // see RULE2
  assign div.run = !s_reg.use_lf && (s_reg.st == MCRO_RUN || s_reg.st == MCRO_TAIL);

  // ***************************************
  // Next state
  // ***************************************
  logic sleep_eff;
  logic at_low;
  logic src_rise;
  logic src_lvl;
  logic rst_active;
  logic hit_ctl;
  logic hit_op;
  logic hit_st;
  logic wr_acc;

  always_comb begin
    s_next = s_reg;
    // A pending interrupt masks the sleep request until it is read
    sleep_eff = sleep_cmd && !irq_pending; // see RULE11 see RULE12
    // Slow source counts as low only once the pin has shown low too
    at_low = s_reg.use_lf ? (!s_reg.lf_q && !s_reg.lf_prev) : div.cyc_end;
    src_rise = s_reg.use_lf ? (s_reg.lf_q && !s_reg.lf_prev) : div.rise;
    src_lvl = s_reg.use_lf ? s_reg.lf_q : div.lvl; // see RULE4
    rst_active = s_reg.swcnt != '0;
    hit_ctl = addr_hit(paddr, CLKCTL_ADDR);
    hit_op = addr_hit(paddr, OPCTL_ADDR);
    hit_st = addr_hit(paddr, STAT_ADDR);
    wr_acc = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;

    s_next.lf_q = lf_clk_in;
    s_next.lf_prev = s_reg.lf_q;
    s_next.pready = 1'b1;

    // APB setup phase: decode and latch the answer
    if (psel && !penable) begin
      s_next.pslverr = !(hit_ctl || hit_op || hit_st);
      s_next.prdata = '0;
      if (hit_ctl) begin
        s_next.prdata[SEL_LSB +: 3] = s_reg.sel;
        s_next.prdata[LFC_BIT] = s_reg.lfc;
        s_next.prdata[TAIL_LSB +: 2] = s_reg.tail;
      end else if (hit_st) begin
        s_next.prdata[3:0] = s_reg.st;
        s_next.prdata[4] = s_reg.xtal_en;
        s_next.prdata[5] = sleep_eff;
        s_next.prdata[6] = rst_active;
        s_next.prdata[7] = s_reg.use_lf;
      end
    end

    // Register writes are ignored while the soft reset pulse runs
    if (wr_acc && pstrb[0] && !rst_active) begin
      if (hit_ctl) begin
        s_next.sel = pwdata[SEL_LSB +: 3];
        s_next.lfc = pwdata[LFC_BIT];
        s_next.tail = pwdata[TAIL_LSB +: 2];
      end else if (hit_op && pwdata[SWRST_BIT]) begin
        s_next.swcnt = SWRST_W'(SWRST_LEN); // see RULE16
      end
    end

    // Soft reset pulse holds configuration at defaults
    if (rst_active) begin
      s_next.swcnt = s_reg.swcnt - 1'b1; // see RULE16
      s_next.sel = CLKCTL_RESET[SEL_LSB +: 3]; // see RULE5 see RULE14
      s_next.lfc = CLKCTL_RESET[LFC_BIT]; // see RULE14
      s_next.tail = CLKCTL_RESET[TAIL_LSB +: 2]; // see RULE14
    end
    s_next.gp_rst = s_next.swcnt != '0; // see RULE15
    s_next.gp_rst_n = !s_next.gp_rst; // see RULE15

    // Output source state machine
    case (s_reg.st)
      MCRO_RUN: begin
        if ((s_reg.use_lf != (s_reg.sel == SEL_LF)) && at_low) begin
          s_next.use_lf = s_reg.sel == SEL_LF; // see RULE17
        end
        if (sleep_eff && s_reg.lfc) begin
          if (at_low) begin
            s_next.st = MCRO_LFC; // see RULE8 see RULE17
            s_next.use_lf = 1'b1;
          end
        end else if (sleep_eff && s_reg.tail != 2'h0) begin
          s_next.st = MCRO_TAIL; // see RULE10
          s_next.tcnt = '0;
        end else if (sleep_eff && at_low) begin
          s_next.st = MCRO_STOP; // see RULE9 see RULE17
        end
      end
      MCRO_TAIL: begin
        if (!sleep_eff) begin
          s_next.st = MCRO_RUN; // see RULE11
        end else if (s_reg.tcnt >= mcro_tail_len(s_reg.tail) && at_low) begin
          s_next.st = MCRO_STOP; // see RULE10 see RULE17
        end else if (src_rise && s_reg.tcnt < mcro_tail_len(s_reg.tail)) begin
          s_next.tcnt = s_reg.tcnt + 10'h001; // see RULE10
        end
      end
      MCRO_LFC: begin
        if (!sleep_eff && !s_reg.lf_q) begin
          s_next.st = MCRO_RUN; // see RULE11 see RULE17
        end
      end
      MCRO_STOP: begin
        if (!sleep_eff) begin
          s_next.st = MCRO_RUN; // see RULE11
        end
      end
      default: begin
        s_next.st = MCRO_RUN;
      end
    endcase

    // Pin drive from the state just chosen, registered
    case (s_next.st)
      MCRO_RUN, MCRO_TAIL: s_next.host_clk = (s_next.use_lf == s_reg.use_lf) ? src_lvl : 1'b0; // see RULE1 see RULE6
      MCRO_LFC: s_next.host_clk = s_reg.use_lf ? s_reg.lf_q : 1'b0; // see RULE8
      default: s_next.host_clk = 1'b0; // see RULE9
    endcase
    // Crystal runs unless the chip really sleeps
    s_next.xtal_en = !(s_next.st == MCRO_STOP || s_next.st == MCRO_LFC); // see RULE7 see RULE13
  end

  // ***************************************
  // State register
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= MCRO_RUN;
      s_reg.sel <= CLKCTL_RESET[SEL_LSB +: 3]; // see RULE5 see RULE14
      s_reg.lfc <= CLKCTL_RESET[LFC_BIT];
      s_reg.tail <= CLKCTL_RESET[TAIL_LSB +: 2];
      s_reg.xtal_en <= 1'b1;
      s_reg.gp_rst <= 1'b1; // see RULE15
      s_reg.gp_rst_n <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign host_clock_out_pin = s_reg.host_clk;
  assign gp_reset_out = s_reg.gp_rst;
  assign gp_reset_n_out = s_reg.gp_rst_n;
  assign xtal_enable = s_reg.xtal_en;

  // ***************************************
  // Checks
  // ***************************************
  logic [SWRST_W-1:0] len_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_cnt <= '0;
    end else if (s_reg.gp_rst) begin
      len_cnt <= len_cnt + 1'b1;
    end else begin
      len_cnt <= '0;
    end
  end

  chk_swrst_pulse_len: assert property (@(posedge pclk) disable iff (!presetn) // see RULE16
    $fell(s_reg.gp_rst) && $past(len_cnt) != '0 |-> len_cnt == SWRST_W'(SWRST_LEN))
    else $error("software reset pulse has the wrong length");

  chk_swrst_defaults: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
    s_reg.swcnt != '0 |=> s_reg.sel == CLKCTL_RESET[SEL_LSB +: 3] && !s_reg.lfc && s_reg.tail == 2'h0)
    else $error("configuration not at defaults during soft reset");

  chk_gp_pins_inverse: assert property (@(posedge pclk) disable iff (!presetn) // see RULE15
    s_reg.gp_rst_n != s_reg.gp_rst && (s_reg.gp_rst == (s_reg.swcnt != '0) || !$past(presetn)))
    else $error("reset pins disagree with reset pulse");

  chk_xtal_off_sleep: assert property (@(posedge pclk) disable iff (!presetn) // see RULE7
    s_reg.xtal_en == !(s_reg.st == MCRO_STOP || s_reg.st == MCRO_LFC))
    else $error("crystal enable does not follow sleep state");

  chk_irq_holds_run: assert property (@(posedge pclk) disable iff (!presetn) // see RULE13
    irq_pending && s_reg.st == MCRO_RUN |=> s_reg.st == MCRO_RUN && s_reg.xtal_en)
    else $error("sleep entered while an interrupt was pending");

  chk_lfc_output: assert property (@(posedge pclk) disable iff (!presetn) // see RULE8
    s_reg.st == MCRO_LFC && s_reg.use_lf ##1 s_reg.st == MCRO_LFC |-> s_reg.host_clk == $past(s_reg.lf_q))
    else $error("slow clock not on the host pin in sleep");

  chk_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see RULE9
    s_reg.st == MCRO_STOP |-> !s_reg.host_clk)
    else $error("host clock toggles while stopped");

  chk_tail_complete: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
    s_reg.st == MCRO_TAIL ##1 s_reg.st == MCRO_STOP |-> $past(s_reg.tcnt) == mcro_tail_len($past(s_reg.tail)))
    else $error("clock stopped before the tail was complete");

  chk_stop_at_low: assert property (@(posedge pclk) disable iff (!presetn) // see RULE17
    s_reg.st != MCRO_STOP ##1 s_reg.st == MCRO_STOP |-> !$past(s_reg.host_clk))
    else $error("clock stopped during a high phase");

  chk_run_follows_div: assert property (@(posedge pclk) disable iff (!presetn) // see RULE6
    s_reg.st == MCRO_RUN && !s_reg.use_lf ##1 s_reg.st == MCRO_RUN && !s_reg.use_lf
      |-> s_reg.host_clk == $past(div.lvl))
    else $error("host clock does not follow the divider");

endmodule

// ---- logic/mcro_pkg.sv ----
package mcro_pkg;

  // ***************************************
  // Clocking and timing
  // ***************************************
  localparam int unsigned PCLK_HZ = 25_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned SWRST_MIN_US = 50;
  localparam int unsigned SWRST_MAX_US = 470;
  // Least time rounds up, longest time rounds down
  localparam int unsigned SWRST_MIN_CYC = (SWRST_MIN_US * PCLK_HZ + US_PER_S - 1) / US_PER_S;
  // Scaled per microsecond first, as the plain product overflows 32 bits
  localparam int unsigned SWRST_MAX_CYC = SWRST_MAX_US * (PCLK_HZ / US_PER_S);
  localparam int unsigned SWRST_W = 14;

  // ***************************************
  // Register map (printed offsets are word indexes)
  // ***************************************
  localparam int unsigned APB_AW = 12;
  localparam logic [7:0] CLKCTL_IDX = 8'h0a;
  localparam logic [7:0] OPCTL_IDX = 8'h08;
  localparam logic [7:0] STAT_IDX = 8'h0c;
  localparam logic [APB_AW-1:0] CLKCTL_ADDR = {2'h0, CLKCTL_IDX, 2'h0};
  localparam logic [APB_AW-1:0] OPCTL_ADDR = {2'h0, OPCTL_IDX, 2'h0};
  localparam logic [APB_AW-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
  localparam logic [7:0] CLKCTL_RESET = 8'h06;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned LFC_BIT = 3;
  localparam int unsigned TAIL_LSB = 4;
  localparam int unsigned SWRST_BIT = 7;
  localparam logic [2:0] SEL_LF = 3'h7;

  // ***************************************
  // Divider periods in half crystal cycles
  // ***************************************
  localparam int unsigned PER_W = 7;
  localparam logic [PER_W-1:0] PER_DIV1 = 7'h02;
  localparam logic [PER_W-1:0] PER_DIV2 = 7'h04;
  localparam logic [PER_W-1:0] PER_DIV3 = 7'h06;
  localparam logic [PER_W-1:0] PER_DIV7P5 = 7'h0f;
  localparam logic [PER_W-1:0] PER_DIV10 = 7'h14;
  localparam logic [PER_W-1:0] PER_DIV15 = 7'h1e;
  localparam logic [PER_W-1:0] PER_DIV30 = 7'h3c;

  // ***************************************
  // Clock tail lengths
  // ***************************************
  localparam logic [9:0] TAIL_LEN0 = 10'h000;
  localparam logic [9:0] TAIL_LEN1 = 10'h080;
  localparam logic [9:0] TAIL_LEN2 = 10'h100;
  localparam logic [9:0] TAIL_LEN3 = 10'h200;

  typedef enum logic [3:0] {
    MCRO_RUN = 4'h1,
    MCRO_TAIL = 4'h2,
    MCRO_LFC = 4'h4,
    MCRO_STOP = 4'h8
  } mcro_state_e;

  function automatic logic [PER_W-1:0] mcro_period(input logic [2:0] sel);
    case (sel)
      3'h0: mcro_period = PER_DIV1;
      3'h1: mcro_period = PER_DIV2;
      3'h2: mcro_period = PER_DIV3;
      3'h3: mcro_period = PER_DIV7P5;
      3'h4: mcro_period = PER_DIV10;
      3'h5: mcro_period = PER_DIV15;
      default: mcro_period = PER_DIV30;
    endcase
  endfunction

  function automatic logic [9:0] mcro_tail_len(input logic [1:0] t);
    case (t)
      2'h1: mcro_tail_len = TAIL_LEN1;
      2'h2: mcro_tail_len = TAIL_LEN2;
      2'h3: mcro_tail_len = TAIL_LEN3;
      default: mcro_tail_len = TAIL_LEN0;
    endcase
  endfunction

endpackage

// ---- logic/mcro_div_if.sv ----
`timescale 1ns/10ps
interface mcro_div_if;
  logic [mcro_pkg::PER_W-1:0] period;
  logic run;
  logic lvl;
  logic cyc_end;
  logic rise;
  modport ctrl (output period, output run, input lvl, input cyc_end, input rise);
  modport gen (input period, input run, output lvl, output cyc_end, output rise);
endinterface

// ---- logic/mcro_divgen.sv ----
`timescale 1ns/10ps
module mcro_divgen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  mcro_div_if.gen g
);
  import mcro_pkg::*;

  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] per;
    logic lvl;
    logic cyc_end;
    logic rise;
  } mcro_div_s;

  mcro_div_s s_reg;
  mcro_div_s s_next;

  // ***************************************
  // Integer divider of the crystal ticks
  // ***************************************
  always_comb begin
    s_next = s_reg;
    s_next.cyc_end = 1'b0;
    s_next.rise = 1'b0;
    if (!g.run) begin
      // Idle just before a wrap, so a start begins with a full high phase
      s_next.cnt = g.period - 7'h01;
      s_next.per = g.period;
      s_next.lvl = 1'b0;
    end else if (s_reg.cnt >= s_reg.per - 7'h01) begin
      // New period only taken at a cycle boundary to avoid a runt pulse
      s_next.cnt = '0;
      s_next.per = g.period; // see RULE17
      s_next.cyc_end = 1'b1;
      s_next.rise = 1'b1;
      s_next.lvl = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 7'h01; // see RULE3
      s_next.lvl = s_next.cnt < (s_reg.per >> 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      // One-tick period wraps at once, so the first edge after reset starts a high phase
      s_reg.per <= 7'h01;
    end else begin
      s_reg <= s_next;
    end
  end

  assign g.lvl = s_reg.lvl;
  assign g.cyc_end = s_reg.cyc_end;
  assign g.rise = s_reg.rise;

  chk_rise_at_boundary: assert property (@(posedge pclk) disable iff (!presetn) // see RULE17
    $rose(s_reg.lvl) |-> s_reg.cyc_end)
    else $error("divider output rose away from a cycle boundary");

endmodule

// ---- sim/mcro_host_model.sv ----
`timescale 1ns/10ps
// ***************************************
// Host clocked from the output pin
// ***************************************
// Measures the last high and low widths in pclk cycles and counts rising edges.
// Four-state compares are used so an unknown pin shows up as a change.
module mcro_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host clock as seen by the host
  input wire logic clk_in,
  // Measurements
  output int unsigned hi_w,
  output int unsigned lo_w,
  output int unsigned rises
);
  logic last;
  int unsigned run;

  // A shortened pulse shows up as a short width here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
      run <= 0;
      hi_w <= 0;
      lo_w <= 0;
      rises <= 0;
    end else begin
      last <= clk_in;
      if (clk_in !== last) begin
        run <= 1;
        if (clk_in === 1'b1) begin
          lo_w <= run;
          rises <= rises + 1;
        end else begin
          hi_w <= run;
        end
      end else begin
        run <= run + 1;
      end
    end
  end
endmodule

// ---- sim/mcro_top_bench.sv ----
`timescale 1ns/10ps
module mcro_top_bench;
  import mcro_pkg::*;
  localparam int unsigned SW_LEN = 8;
  localparam int unsigned LF_HALF = 381;
  typedef struct {logic [2:0] sel; int unsigned hi; int unsigned lo;} mcro_row_s;
  logic pclk, presetn, psel, penable, pwrite, sleep_cmd, irq_pending, lf_clk_in;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic pready, pslverr, rerr, host_clock_out_pin, gp_reset_out, gp_reset_n_out, xtal_enable;
  int unsigned hi_w, lo_w, rises, n_mismatch, total_checks, cyc, lf_cnt, base, k;
  mcro_row_s rows [8] = '{'{3'h0, 1, 1}, '{3'h1, 2, 2}, '{3'h2, 3, 3}, '{3'h3, 7, 8},
    '{3'h4, 10, 10}, '{3'h5, 15, 15}, '{3'h6, 30, 30}, '{3'h7, LF_HALF, LF_HALF}};
  int unsigned tails [4] = '{0, 128, 256, 512};

  mcro_top #(.SWRST_LEN(SW_LEN)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_cmd(sleep_cmd), .irq_pending(irq_pending), .lf_clk_in(lf_clk_in),
    .host_clock_out_pin(host_clock_out_pin), .gp_reset_out(gp_reset_out),
    .gp_reset_n_out(gp_reset_n_out), .xtal_enable(xtal_enable));
  mcro_host_model host (.pclk(pclk), .presetn(presetn), .clk_in(host_clock_out_pin), .hi_w(hi_w),
    .lo_w(lo_w), .rises(rises));

  // ***************************************
  // Clock, slow source and timeout
  // ***************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Slow source is a data level for the block, so it is made on pclk
  always @(posedge pclk) begin
    if (lf_cnt == LF_HALF - 1) begin
      lf_cnt <= 0;
      lf_clk_in <= ~lf_clk_in;
    end else begin
      lf_cnt <= lf_cnt + 1;
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ***************************************
  // Tasks
  // ***************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_xtal(input logic v);
    k = 0;
    while (xtal_enable !== v && k < 40000) begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h1;
    sleep_cmd = 1'b0;
    irq_pending = 1'b0;
    lf_clk_in = 1'b0;
    lf_cnt = 0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge pclk);
    chk("reset_out_in_reset", 1, gp_reset_out);
    chk("reset_n_in_reset", 0, gp_reset_n_out);
    presetn <= 1'b1;
    cycles(200);
    chk("reset_out_run", 0, gp_reset_out);
    chk("reset_n_run", 1, gp_reset_n_out);
    chk("hi_default", 30, hi_w);
    chk("lo_default", 30, lo_w);
    apb(1'b0, CLKCTL_ADDR, 32'h0);
    chk("clkctl_reset", {24'h0, CLKCTL_RESET}, rdat);
    apb(1'b0, 12'h3fc, 32'h0);
    chk("unmapped_err", 1, rerr);
    chk("unmapped_data", 0, rdat);
    // Every select code, crystal options and the slow option
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, CLKCTL_ADDR, {29'h0, rows[i].sel});
      cycles(1600);
      chk("hi_width", rows[i].hi, hi_w);
      chk("lo_width", rows[i].lo, lo_w);
      apb(1'b0, CLKCTL_ADDR, 32'h0);
      chk("clkctl_read", {29'h0, rows[i].sel}, rdat);
    end
    // Sleep without slow clock: tail then stop, entered mid high pulse
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, CLKCTL_ADDR, {26'h0, t[1:0], 4'h5});
      cycles(100);
      base = rises;
      k = 0;
      while (rises == base && k < 1000) begin
        @(posedge pclk);
        k++;
      end
      base = rises;
      sleep_cmd <= 1'b1;
      wait_xtal(1'b0);
      cycles(100);
      chk("tail_rises", tails[t], rises - base);
      chk("pin_stopped", 0, host_clock_out_pin);
      chk("xtal_sleep", 0, xtal_enable);
      sleep_cmd <= 1'b0;
      cycles(100);
      chk("xtal_wake", 1, xtal_enable);
    end
    // Pending interrupt holds off sleep
    irq_pending <= 1'b1;
    sleep_cmd <= 1'b1;
    cycles(300);
    chk("xtal_held", 1, xtal_enable);
    base = rises;
    cycles(100);
    chk("clock_held", 1, rises != base);
    irq_pending <= 1'b0;
    wait_xtal(1'b0);
    chk("sleep_after_read", 0, xtal_enable);
    irq_pending <= 1'b1;
    cycles(50);
    chk("irq_wakes", 1, xtal_enable);
    irq_pending <= 1'b0;
    sleep_cmd <= 1'b0;
    // Sleep with slow clock enabled while select asks for the fastest crystal option
    apb(1'b1, CLKCTL_ADDR, 32'h08);
    sleep_cmd <= 1'b1;
    cycles(2000);
    chk("xtal_lfc", 0, xtal_enable);
    chk("lfc_hi", LF_HALF, hi_w);
    chk("lfc_lo", LF_HALF, lo_w);
    sleep_cmd <= 1'b0;
    cycles(100);
    // Software reset pulse and register defaults
    apb(1'b1, CLKCTL_ADDR, 32'h31);
    apb(1'b1, OPCTL_ADDR, 32'h80);
    base = 0;
    k = 0;
    repeat (20) begin
      @(posedge pclk);
      if (gp_reset_out === 1'b1)
        base++;
      if (gp_reset_n_out !== ~gp_reset_out)
        k++;
    end
    chk("swrst_len", SW_LEN, base);
    chk("reset_pair", 0, k);
    apb(1'b0, CLKCTL_ADDR, 32'h0);
    chk("clkctl_after_swrst", {24'h0, CLKCTL_RESET}, rdat);
    // Second hardware reset in mid-run
    apb(1'b1, CLKCTL_ADDR, 32'h23);
    presetn <= 1'b0;
    cycles(3);
    chk("xtal_in_reset", 1, xtal_enable);
    presetn <= 1'b1;
    cycles(2);
    apb(1'b0, CLKCTL_ADDR, 32'h0);
    chk("clkctl_after_reset", {24'h0, CLKCTL_RESET}, rdat);
    report_and_stop();
  end
endmodule
